// >>> rtl/mmu_fault_map.svh
`ifndef MMU_FAULT_MAP_SVH
`define MMU_FAULT_MAP_SVH

// apb byte offsets
`define OFF_DOMAIN_MAP 12'h000
`define OFF_CONTROL 12'h004
`define OFF_FAULT_STATUS 12'h008
`define OFF_FAULT_ADDR 12'h00c

// control register bits
`define CTL_ALIGN_BIT 1
`define CTL_SYSPROT_BIT 8

// reset values
`define RST_DOMAIN_MAP 32'h0000_0000
`define RST_CONTROL 32'h0000_0000

// fault class codes
`define FC_WBUF_ERR 4'h0
`define FC_ALIGN 4'h1
`define FC_LINE_ERR 4'h4
`define FC_SEC_XLATE 4'h5
`define FC_PAGE_XLATE 4'h7
`define FC_SEC_DOMAIN 4'h9
`define FC_PAGE_DOMAIN 4'hb
`define FC_WALK1_ERR 4'hc
`define FC_SEC_PERM 4'hd
`define FC_WALK2_ERR 4'he
`define FC_PAGE_PERM 4'hf

// descriptor field positions
`define L1_DOMAIN_HI 8
`define L1_DOMAIN_LO 5
`define L1_PERM_HI 11
`define L1_PERM_LO 10
`define L2_PERM_LO 4

`endif

// >>> rtl/mmu_fault_pkg.sv
package mmu_fault_pkg;
  typedef enum logic [1:0] {
    DOM_NONE = 2'b00,
    DOM_CLIENT = 2'b01,
    DOM_RSVD = 2'b10,
    DOM_MANAGER = 2'b11
  } domain_mode_t;
  typedef enum logic [1:0] {
    DESC_INVALID = 2'b00,
    DESC_PAGE = 2'b01,
    DESC_SECTION = 2'b10,
    DESC_RSVD = 2'b11
  } l1_type_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_L1 = 2'b01,
    ST_WAIT_L2 = 2'b10,
    ST_DONE = 2'b11
  } check_state_t;
endpackage

// >>> rtl/mmu_fault_checker.sv
// Operation
// - alignment, translation, domain, permission faults abort and report
// - violations found before external cycle; external access suppressed
// - external aborts do not inhibit the bus access in advance
// - data abort writes 4-bit fault code and domain into status register
// - data abort captures faulting virtual address
// - simultaneous sources record only highest priority one
// - prefetch fault tags instruction; abort only if executed
// - prefetch abort leaves status and address registers unchanged
// - fault code encodings for translation, domain, permission, walk errors
// - alignment coded 00x1, domain undefined
// - write-buffer error coded 00x0, address of first abortable operation
// - linefetch error coded 0100; domain and address valid on word 0
// - section translation fault records descriptor bits 8:5 as domain
// - domain map holds sixteen 2-bit fields selected by domain number
// - domain 00 and 10 fault, 01 client checks, 11 manager skips
// - alignment enable faults word accesses with nonzero address bits 1:0
// - no alignment fault on fetch or byte; alignment ends the sequence
// - level-one type 00 or 11 gives section translation fault
// - level-two type 00 or 11 gives page translation fault
// - domain checked on l1 for sections, on l2 for pages
// - permission checked with domain, only for client domains
// - section permission decode uses bit 8; violation gives section fault
// - page quarter picks permission field: 1kB small, 16kB large
// - sub-page field decoded as section; violation is sub-page fault
// - perm 00 none or sup read, 01 sup rw, 10 user ro, 11 all
// - domain number from level-one bits 8:5
// - sub-page permissions from level-two bits 11:4
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "mmu_fault_map.svh"

module mmu_fault_checker #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core access request
  input wire logic acc_req,
  input wire logic [31:0] acc_vaddr,
  input wire logic acc_fetch,
  input wire logic acc_byte,
  input wire logic acc_write,
  input wire logic acc_user,
  // translation walker results
  input wire logic l1_valid,
  input wire logic [31:0] l1_desc,
  input wire logic l1_bus_err,
  input wire logic l2_valid,
  input wire logic [31:0] l2_desc,
  input wire logic l2_bus_err,
  // external bus errors
  input wire logic line_err,
  input wire logic [3:0] line_err_domain,
  input wire logic wbuf_err,
  input wire logic [31:0] wbuf_addr,
  // prefetch execution from pipeline
  input wire logic exec_tagged,
  // outputs to core and bus
  output logic check_done,
  output logic ext_go,
  output logic data_abort,
  output logic prefetch_tag,
  output logic prefetch_abort
);
  import mmu_fault_pkg::*;

  // the highest register offset needs four address bits
  if (ADDR_W < 4) begin : g_addr_w_check
    $error("ADDR_W too small");
  end

  logic [31:0] domain_permission_map;
  logic [31:0] control;
  logic [7:0] fault_status_reg;
  logic [31:0] fault_address_reg;
  check_state_t state;
  logic [31:0] cur_vaddr;
  logic cur_fetch, cur_byte, cur_write, cur_user, cur_page;
  logic [3:0] cur_dom;
  logic fault_hit;
  logic [3:0] fault_code;
  logic [3:0] fault_dom;
  logic done_fault;
  logic tag_pending;

  // apb
  logic wr_en, rd_en;
  logic [ADDR_W-1:0] reg_off;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign reg_off = paddr & ~ADDR_W'(3);
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      domain_permission_map <= `RST_DOMAIN_MAP;
      control <= `RST_CONTROL;
    end else if (wr_en) begin
      if (reg_off == ADDR_W'(`OFF_DOMAIN_MAP))
        domain_permission_map <= pwdata;
      if (reg_off == ADDR_W'(`OFF_CONTROL))
        control <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_en) begin
      pslverr <= 1'b0;
      unique case (reg_off)
        ADDR_W'(`OFF_DOMAIN_MAP): prdata <= domain_permission_map;
        ADDR_W'(`OFF_CONTROL): prdata <= control;
        ADDR_W'(`OFF_FAULT_STATUS): prdata <= {24'h0, fault_status_reg};
        ADDR_W'(`OFF_FAULT_ADDR): prdata <= fault_address_reg;
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      endcase
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      pslverr <= !(reg_off == ADDR_W'(`OFF_DOMAIN_MAP) ||
                   reg_off == ADDR_W'(`OFF_CONTROL) ||
                   reg_off == ADDR_W'(`OFF_FAULT_STATUS) ||
                   reg_off == ADDR_W'(`OFF_FAULT_ADDR));
    end
  end

  // permission decode, shared by section and sub-page
  function automatic logic perm_ok(input logic [1:0] p, input logic s,
                                   input logic user, input logic wr);
    logic ok;
    ok = 1'b0;
    unique case (p)
      2'b00: ok = s && !user && !wr;
      2'b01: ok = !user;
      2'b10: ok = !user || !wr;
      2'b11: ok = 1'b1;
    endcase
    return ok;
  endfunction

  // checks on a returned descriptor
  logic [3:0] l1_dom;
  domain_mode_t dmode;
  l1_type_t l1_type;
  logic [1:0] sec_perm, sub_perm, l2_type;
  logic [1:0] quarter;
  logic mis_align;
  assign l1_dom = l1_desc[`L1_DOMAIN_HI:`L1_DOMAIN_LO];
  assign l1_type = l1_type_t'(l1_desc[1:0]);
  assign l2_type = l2_desc[1:0];
  assign dmode = domain_mode_t'(domain_permission_map[
                   {(state == ST_WAIT_L2 ? cur_dom : l1_dom), 1'b0} +: 2]);
  assign sec_perm = l1_desc[`L1_PERM_HI:`L1_PERM_LO];
  // small page quarters at 1kB, large at 16kB
  assign quarter = (l2_type == 2'b01) ? cur_vaddr[15:14] : cur_vaddr[11:10];
  assign sub_perm = l2_desc[`L2_PERM_LO + 2*quarter +: 2];
  assign mis_align = control[`CTL_ALIGN_BIT] && !acc_fetch && !acc_byte &&
                     (acc_vaddr[1:0] != 2'b00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cur_vaddr <= 32'h0;
      cur_fetch <= 1'b0;
      cur_byte <= 1'b0;
      cur_write <= 1'b0;
      cur_user <= 1'b0;
      cur_page <= 1'b0;
      cur_dom <= 4'h0;
      fault_hit <= 1'b0;
      fault_code <= 4'h0;
      fault_dom <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          fault_hit <= 1'b0;
          if (acc_req) begin
            cur_vaddr <= acc_vaddr;
            cur_fetch <= acc_fetch;
            cur_byte <= acc_byte;
            cur_write <= acc_write;
            cur_user <= acc_user;
            if (mis_align) begin
              fault_hit <= 1'b1;
              fault_code <= `FC_ALIGN;
              fault_dom <= 4'h0;
              state <= ST_DONE;
            end else begin
              state <= ST_WAIT_L1;
            end
          end
        end
        ST_WAIT_L1: begin
          if (l1_valid || l1_bus_err) begin
            cur_dom <= l1_dom;
            cur_page <= (l1_type == DESC_PAGE);
            state <= ST_DONE;
            if (l1_bus_err) begin
              fault_hit <= 1'b1;
              fault_code <= `FC_WALK1_ERR;
              fault_dom <= l1_dom;
            end else if (l1_type == DESC_INVALID || l1_type == DESC_RSVD) begin
              fault_hit <= 1'b1;
              fault_code <= `FC_SEC_XLATE;
              fault_dom <= l1_dom;
            end else if (l1_type == DESC_PAGE) begin
              state <= ST_WAIT_L2;
            end else if (dmode == DOM_NONE || dmode == DOM_RSVD) begin
              fault_hit <= 1'b1;
              fault_code <= `FC_SEC_DOMAIN;
              fault_dom <= l1_dom;
            end else if (dmode == DOM_CLIENT &&
                         !perm_ok(sec_perm, control[`CTL_SYSPROT_BIT],
                                  cur_user, cur_write)) begin
              fault_hit <= 1'b1;
              fault_code <= `FC_SEC_PERM;
              fault_dom <= l1_dom;
            end
          end
        end
        ST_WAIT_L2: begin
          if (l2_valid || l2_bus_err) begin
            state <= ST_DONE;
            fault_dom <= cur_dom;
            if (l2_bus_err) begin
              fault_hit <= 1'b1;
              fault_code <= `FC_WALK2_ERR;
            end else if (l2_type == 2'b00 || l2_type == 2'b11) begin
              fault_hit <= 1'b1;
              fault_code <= `FC_PAGE_XLATE;
            end else if (dmode == DOM_NONE || dmode == DOM_RSVD) begin
              fault_hit <= 1'b1;
              fault_code <= `FC_PAGE_DOMAIN;
            end else if (dmode == DOM_CLIENT &&
                         !perm_ok(sub_perm, control[`CTL_SYSPROT_BIT],
                                  cur_user, cur_write)) begin
              fault_hit <= 1'b1;
              fault_code <= `FC_PAGE_PERM;
            end
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign done_fault = (state == ST_DONE) && fault_hit;
  assign check_done = (state == ST_DONE);
  assign ext_go = (state == ST_DONE) && !fault_hit;
  assign data_abort = done_fault && !cur_fetch;
  assign prefetch_tag = done_fault && cur_fetch;

  // prefetch tag held until the tagged instruction executes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_pending <= 1'b0;
      prefetch_abort <= 1'b0;
    end else begin
      prefetch_abort <= tag_pending && exec_tagged;
      if (prefetch_tag)
        tag_pending <= 1'b1;
      else if (exec_tagged)
        tag_pending <= 1'b0;
    end
  end

  // status capture; external errors outrank internal faults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_status_reg <= 8'h00;
      fault_address_reg <= 32'h0;
    end else if (wbuf_err) begin
      fault_status_reg <= {4'h0, `FC_WBUF_ERR};
      fault_address_reg <= wbuf_addr;
    end else if (line_err) begin
      fault_status_reg <= {line_err_domain, `FC_LINE_ERR};
      fault_address_reg <= cur_vaddr;
    end else if (data_abort) begin
      fault_status_reg <= {fault_dom, fault_code};
      fault_address_reg <= cur_vaddr;
    end
  end

  sequence s_abort_seen;
    data_abort && !wbuf_err && !line_err;
  endsequence

  sequence s_section_back;
    state == ST_WAIT_L1 && l1_valid && !l1_bus_err &&
      l1_type == DESC_SECTION;
  endsequence

  sequence s_page_entry_back;
    state == ST_WAIT_L2 && l2_valid && !l2_bus_err;
  endsequence

  a_status_capture: assert property (@(posedge pclk) disable iff (!presetn)
    s_abort_seen |=> fault_status_reg == {$past(fault_dom), $past(fault_code)})
    else $error("status not captured");
  a_addr_capture: assert property (@(posedge pclk) disable iff (!presetn)
    s_abort_seen |=> fault_address_reg == $past(cur_vaddr))
    else $error("address not captured");
  a_prefetch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (prefetch_tag && !wbuf_err && !line_err) |=> $stable(fault_status_reg))
    else $error("prefetch changed status");
  a_no_ext_fault: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_WAIT_L1 && l1_bus_err) |=> (check_done && !ext_go))
    else $error("faulted access reached bus");
  a_align_fast: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE && acc_req && mis_align) |=> ##0
    (data_abort && fault_code == `FC_ALIGN))
    else $error("alignment fault missing");
  a_no_align_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE && acc_req && (acc_fetch || acc_byte)) |=>
    !(fault_hit && fault_code == `FC_ALIGN))
    else $error("alignment on fetch or byte");
  a_prefetch_exec: assert property (@(posedge pclk) disable iff (!presetn)
    prefetch_abort |-> $past(tag_pending) && $past(exec_tagged))
    else $error("prefetch abort without exec");
  a_sec_xlate: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_WAIT_L1 && l1_valid && !l1_bus_err &&
     l1_desc[1:0] == 2'b11) |=> (fault_hit && fault_code == `FC_SEC_XLATE))
    else $error("section translation missed");
  a_status_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!data_abort && !wbuf_err && !line_err) |=>
    ($stable(fault_address_reg) && $stable(fault_status_reg)))
    else $error("fault registers changed without abort");
  a_sec_domain: assert property (@(posedge pclk) disable iff (!presetn)
    s_section_back ##0 (dmode == DOM_NONE || dmode == DOM_RSVD) |=>
    (done_fault && fault_code == `FC_SEC_DOMAIN))
    else $error("section domain fault missing");
  a_manager_skip: assert property (@(posedge pclk) disable iff (!presetn)
    s_section_back ##0 (dmode == DOM_MANAGER) |=> ext_go)
    else $error("manager access was checked");
  a_sec_no_access: assert property (@(posedge pclk) disable iff (!presetn)
    s_section_back ##0 (dmode == DOM_CLIENT && sec_perm == 2'b00 &&
      !control[`CTL_SYSPROT_BIT]) |=>
    (done_fault && fault_code == `FC_SEC_PERM))
    else $error("section permission fault missing");
  a_page_walk: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_WAIT_L1 && l1_valid && !l1_bus_err &&
     l1_type == DESC_PAGE) |=> (state == ST_WAIT_L2 && !check_done))
    else $error("page entry not fetched");
  a_page_xlate: assert property (@(posedge pclk) disable iff (!presetn)
    s_page_entry_back ##0 (l2_type == 2'b00 || l2_type == 2'b11) |=>
    (done_fault && fault_code == `FC_PAGE_XLATE))
    else $error("page translation missed");
  a_page_domain: assert property (@(posedge pclk) disable iff (!presetn)
    s_page_entry_back ##0 (l2_type == 2'b01 || l2_type == 2'b10) ##0
    (dmode == DOM_NONE || dmode == DOM_RSVD) |=>
    (done_fault && fault_code == `FC_PAGE_DOMAIN))
    else $error("page domain fault missing");
  a_fetch_byte_done: assert property (@(posedge pclk) disable iff (!presetn)
    (check_done && (cur_fetch || cur_byte)) |->
    !(fault_hit && fault_code == `FC_ALIGN))
    else $error("alignment fault on fetch or byte");
  a_page_codes: assert property (@(posedge pclk) disable iff (!presetn)
    (done_fault && !cur_page) |-> !(fault_code inside {`FC_PAGE_XLATE,
    `FC_PAGE_DOMAIN, `FC_PAGE_PERM, `FC_WALK2_ERR}))
    else $error("page fault code on section");
  a_tag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_tagged && !prefetch_tag) |=> !tag_pending)
    else $error("prefetch tag not cleared");
  a_ext_go_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    ext_go |=> !ext_go)
    else $error("bus go held too long");
endmodule // mmu_fault_checker

// >>> verification/core_walker_model.sv
`timescale 1ns/1ps
module core_walker_model (
  // clock and request
  input wire logic pclk,
  input wire logic presetn,
  input wire logic acc_req,
  // walk plan
  input wire logic walk,
  input wire logic slow,
  input wire logic [1:0] berr,
  input wire logic [31:0] d1,
  input wire logic [31:0] d2,
  // walker results
  output logic l1_valid,
  output logic l1_bus_err,
  output logic [31:0] l1_desc,
  output logic l2_valid,
  output logic l2_bus_err,
  output logic [31:0] l2_desc
);
  // descriptors show the inverse after their valid cycle, and zero until the first one
  initial begin
    {l1_valid, l1_bus_err, l2_valid, l2_bus_err} = 4'h0;
    {l1_desc, l2_desc} = 64'h0;
    forever begin
      @(posedge pclk);
      if (presetn && acc_req && walk) begin
        repeat (slow ? 3 : 0) @(posedge pclk);
        l1_desc <= d1;
        l1_valid <= (berr != 2'd1);
        l1_bus_err <= (berr == 2'd1);
        @(posedge pclk);
        {l1_valid, l1_bus_err} <= 2'b00;
        l1_desc <= ~d1;
        if (berr != 2'd1 && d1[1:0] == 2'b01) begin
          repeat (slow ? 2 : 0) @(posedge pclk);
          l2_desc <= d2;
          l2_valid <= (berr != 2'd2);
          l2_bus_err <= (berr == 2'd2);
          @(posedge pclk);
          {l2_valid, l2_bus_err} <= 2'b00;
          l2_desc <= ~d2;
        end
      end
    end
  end
endmodule // core_walker_model

// >>> verification/mmu_fault_checker_tb.sv
`timescale 1ns/1ps
module mmu_fault_checker_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, acc_req = 1'b0, acc_fetch = 1'b0, acc_byte = 1'b0;
  logic acc_write = 1'b0, acc_user = 1'b0, line_err = 1'b0, wbuf_err = 1'b0;
  logic exec_tagged = 1'b0, walk = 1'b0, slow = 1'b0, er;
  logic [1:0] berr = 2'h0;
  logic [3:0] line_err_domain = 4'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, acc_vaddr = 32'h0, wbuf_addr = 32'h0;
  logic [31:0] d1 = 32'h0, d2 = 32'h0, ctl = 32'h0, dmap = 32'h0;
  logic [31:0] prdata, l1_desc, l2_desc, rd, exp_fa = 32'h0;
  logic [7:0] exp_fs = 8'h0, fs_mask = 8'hff;
  logic pready, pslverr, l1_valid, l1_bus_err, l2_valid, l2_bus_err;
  logic check_done, ext_go, data_abort, prefetch_tag, prefetch_abort;
  int n_fail = 0, samples_checked = 0;
  integer seed = 32'hf1ebfbbd;

  mmu_fault_checker mmu_fault_checker_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .acc_req, .acc_vaddr, .acc_fetch, .acc_byte,
    .acc_write, .acc_user, .l1_valid, .l1_desc, .l1_bus_err, .l2_valid,
    .l2_desc, .l2_bus_err, .line_err, .line_err_domain, .wbuf_err,
    .wbuf_addr, .exec_tagged, .check_done, .ext_go, .data_abort,
    .prefetch_tag, .prefetch_abort
  );
  core_walker_model core_walker_model_inst (
    .pclk, .presetn, .acc_req, .walk, .slow, .berr, .d1, .d2, .l1_valid,
    .l1_bus_err, .l1_desc, .l2_valid, .l2_bus_err, .l2_desc
  );

  initial begin
    forever #50 pclk = ~pclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    test_done();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // returns {fault, domain, code}
  function automatic logic [8:0] expect_of(input logic [31:0] va,
      input logic f, b, w, u, input logic [31:0] x1, x2,
      input logic [1:0] be);
    logic [3:0] dom;
    logic [1:0] dm, ap;
    logic pg, ok;
    dom = x1[8:5];
    pg = (x1[1:0] == 2'b01);
    if (ctl[1] && !f && !b && va[1:0] != 2'b00) return 9'h101;
    if (be == 2'd1) return {1'b1, dom, 4'hc};
    if (x1[1:0] == 2'b00 || x1[1:0] == 2'b11) return {1'b1, dom, 4'h5};
    if (pg && be == 2'd2) return {1'b1, dom, 4'he};
    if (pg && (x2[1:0] == 2'b00 || x2[1:0] == 2'b11))
      return {1'b1, dom, 4'h7};
    dm = dmap[2 * dom +: 2];
    if (!dm[0]) return {1'b1, dom, pg ? 4'hb : 4'h9};
    if (dm == 2'b11) return 9'h0;
    // large pages use 16kB quarters, small pages 1kB quarters
    ap = pg ? x2[4 + 2 * (x2[1:0] == 2'b01 ? va[15:14] : va[11:10]) +: 2]
        : x1[11:10];
    case (ap)
      2'b00: ok = ctl[8] && !u && !w;
      2'b01: ok = !u;
      2'b10: ok = !u || !w;
      default: ok = 1'b1;
    endcase
    return ok ? 9'h0 : {1'b1, dom, pg ? 4'hf : 4'hd};
  endfunction

  task automatic access(input logic [31:0] va, input logic f, b, w, u,
      input logic [31:0] x1, x2, input logic [1:0] be);
    logic [8:0] e;
    int k;
    e = expect_of(va, f, b, w, u, x1, x2, be);
    k = 0;
    @(posedge pclk);
    acc_req <= 1'b1;
    acc_vaddr <= va;
    {acc_fetch, acc_byte, acc_write, acc_user} <= {f, b, w, u};
    {d1, d2, berr} <= {x1, x2, be};
    walk <= (e != 9'h101);
    slow <= 1'($random(seed));
    @(posedge pclk);
    acc_req <= 1'b0;
    while (k < 20) begin
      #1;
      if (check_done === 1'b1) break;
      @(posedge pclk);
      k++;
    end
    chk({check_done, ext_go, data_abort, prefetch_tag},
        {1'b1, !e[8], e[8] && !f, e[8] && f});
    if (e[8] && !f) begin
      exp_fs = e[7:0];
      fs_mask = (be == 2'd1 || e[3:0] == 4'h1) ? 8'h0f : 8'hff;
      exp_fa = va;
    end
    @(posedge pclk);
    exec_tagged <= f;
    @(posedge pclk);
    exec_tagged <= 1'b0;
    #1 chk(prefetch_abort, e[8] && f);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd & {24'h0, fs_mask}, {24'h0, exp_fs & fs_mask});
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, exp_fa);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk({30'h0, pready, er}, 32'h2);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    dmap = $random(seed);
    apb(1'b1, 12'h000, dmap);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, dmap);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test registers done");
    dmap = 32'h5555_5555;
    ctl = 32'h0000_0100;
    apb(1'b1, 12'h000, dmap);
    apb(1'b1, 12'h004, ctl);
    for (int i = 0; i < 16; i++)
      access(32'h0, 1'b0, 1'b0, i[0], i[1], {20'h0, i[3:2], 10'h2},
          32'h0, 2'h0);
    $display("test permissions done");
    for (int i = 0; i < 150; i++) begin
      if (i % 10 == 0) begin
        ctl = $random(seed) & 32'h0000_0102;
        dmap = $random(seed);
        apb(1'b1, 12'h004, ctl);
        apb(1'b1, 12'h000, dmap);
      end
      access($random(seed), ($random(seed) & 3) == 0, 1'($random(seed)),
          1'($random(seed)), 1'($random(seed)), $random(seed),
          $random(seed), ($random(seed) & 7) == 0 ?
          2'd1 + 2'($random(seed) & 1) : 2'd0);
    end
    $display("test random accesses done");
    @(posedge pclk);
    {wbuf_err, line_err} <= 2'b11;
    wbuf_addr <= $random(seed);
    line_err_domain <= 4'h9;
    @(posedge pclk);
    {wbuf_err, line_err} <= 2'b00;
    apb(1'b0, 12'h008, 32'h0);
    chk(rd & 32'h0f, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, wbuf_addr);
    line_err <= 1'b1;
    @(posedge pclk);
    line_err <= 1'b0;
    apb(1'b0, 12'h008, 32'h0);
    chk(rd & 32'hff, 32'h94);
    $display("test external errors done");
    test_done();
  end
endmodule // mmu_fault_checker_tb
